/* File: design/cpsw_pkg.sv */
// constants, field layout and carriers for the processor status word block
package cpsw_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------
    localparam int unsigned APB_AW = 12;
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_CARRY = 12'h004;
    localparam logic [11:0] OFF_BANK = 12'h008;

    // -------------------------------------------------------------
    // status word layout
    // -------------------------------------------------------------
    localparam int unsigned STATUS_W = 8;
    localparam int unsigned C_BIT = 7;
    localparam int unsigned SC_LSB = 4;
    localparam int unsigned SC_W = 3;
    localparam int unsigned IS_LSB = 2;
    localparam int unsigned IS_W = 2;
    localparam int unsigned MEM_EN_BIT = 1;
    localparam int unsigned REG_EN_BIT = 0;
    // carry position in the single-bit access register
    localparam int unsigned BIT_ACC_POS = 0;
    localparam logic [2:0] SC_RESET = 3'h0;
    localparam logic [1:0] IS_RESET = 2'h0;
    localparam logic MEM_EN_RESET = 1'b0;
    localparam logic REG_EN_RESET = 1'b0;
    localparam logic CARRY_COLD = 1'b0;
    localparam int unsigned BANK_W = 4;
    localparam logic [3:0] BANK_ZERO = 4'h0;

    // service level encodings
    typedef enum logic [1:0] {
        SVC_ALL = 2'h0,
        SVC_HIGH_ONLY = 2'h1,
        SVC_NONE = 2'h2,
        SVC_UNDEF = 2'h3
    } cpsw_svc_e;

    // -------------------------------------------------------------
    // data memory windows
    // -------------------------------------------------------------
    localparam int unsigned DADDR_W = 12;
    localparam logic [11:0] LOW_WIN_MAX = 12'h07F;
    localparam logic [11:0] HIGH_WIN_MIN = 12'hF80;
    localparam logic [3:0] FULL_BANK_MAX = 4'h4;
    localparam logic [3:0] IO_BANK = 4'hF;

    typedef struct packed {
        logic valid;
        logic [11:0] addr;
    } cpsw_dmem_req_s;

    typedef struct packed {
        logic grant;
        logic fault;
    } cpsw_dmem_rsp_s;

    // access window decode, shared by the gate and its checks
    function automatic logic in_window(input logic mem_en, input logic [11:0] addr);
        logic [3:0] bank;
        bank = addr[11:8];
        if (mem_en) begin
            in_window = (bank <= FULL_BANK_MAX) || (bank == IO_BANK);
        end else begin
            in_window = (addr <= LOW_WIN_MAX) || (addr >= HIGH_WIN_MIN);
        end
    endfunction
endpackage

/* File: design/cpsw_dmem_gate.sv */
// data memory access window gate
`timescale 1ns/10ps
`default_nettype none
module cpsw_dmem_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_en,
    input wire cpsw_pkg::cpsw_dmem_req_s req,
    output cpsw_pkg::cpsw_dmem_rsp_s rsp
);
    wire logic ok;
    cpsw_pkg::cpsw_dmem_rsp_s rsp_next;

    assign ok = cpsw_pkg::in_window(mem_en, req.addr);
    assign rsp_next = '{grant: req.valid && ok, fault: req.valid && !ok};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_next;
        end
    end
endmodule // cpsw_dmem_gate
`default_nettype wire

/* File: design/cpsw_status.sv */
// processor status word register bank with apb access
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - carry shows overflow or borrow of arithmetic
// - skip flags read only, software writes ignored
// - one service level encoding selects high-priority only
// - bank flag clear: narrow data memory window
// - bank flag set: banks 0-4 and 15
// - reset in power-down keeps carry value
// - carry only through single-bit access register
module cpsw_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alu_carry_we,
    input wire logic alu_carry,
    input wire logic skip_we,
    input wire logic [2:0] skip_flags_in,
    input wire logic bank_sel_we,
    input wire logic [3:0] bank_sel_in,
    input wire logic power_down,
    input wire cpsw_pkg::cpsw_dmem_req_s dmem_req,
    output cpsw_pkg::cpsw_dmem_rsp_s dmem_rsp,
    output logic [1:0] service_level_field,
    output logic service_high_only,
    output logic [3:0] working_bank
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic carry_reg;
    logic carry_next;
    logic [2:0] sc_reg;
    logic [1:0] is_reg;
    logic mem_en_reg;
    logic reg_en_reg;
    logic [3:0] bank_sel_reg;
    logic first_reg;
    logic pd_last_reg;
    logic [31:0] prdata_next;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // zero wait states: pready is registered straight from setup
    wire logic setup = psel && !penable;
    wire logic wr_done = psel && penable && pready && pwrite;
    wire logic hit_status = (paddr == cpsw_pkg::OFF_STATUS);
    wire logic hit_carry = (paddr == cpsw_pkg::OFF_CARRY);
    wire logic hit_bank = (paddr == cpsw_pkg::OFF_BANK);
    wire logic unmapped = !(hit_status || hit_carry || hit_bank);
    wire logic wr_status = wr_done && hit_status;
    wire logic wr_carry = wr_done && hit_carry;
    wire logic [cpsw_pkg::STATUS_W-1:0] status_view = {carry_reg, sc_reg, is_reg, mem_en_reg, reg_en_reg};
    wire logic [3:0] bank_next = reg_en_reg ? bank_sel_reg : cpsw_pkg::BANK_ZERO;

    // read data captured in setup, so it stands through the access phase
    always_comb begin
        prdata_next = '0;
        if (hit_status) begin
            prdata_next[cpsw_pkg::STATUS_W-1:0] = status_view;
        end else if (hit_carry) begin
            prdata_next[cpsw_pkg::BIT_ACC_POS] = carry_reg;
        end else if (hit_bank) begin
            prdata_next[cpsw_pkg::BANK_W-1:0] = bank_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && unmapped;
            prdata <= setup ? prdata_next : '0;
        end
    end

    // ---------------------------------------------------------------
    // carry flag
    // ---------------------------------------------------------------
    // no async reset here: the value must survive a reset taken in power-down
    always_ff @(posedge pclk) begin
        pd_last_reg <= first_reg ? pd_last_reg : power_down;
    end

    // high through reset and at the first edge after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_comb begin
        carry_next = carry_reg;
        if (first_reg) begin
            carry_next = pd_last_reg ? carry_reg : cpsw_pkg::CARRY_COLD;
        end else if (alu_carry_we) begin
            carry_next = alu_carry;
        end else if (wr_carry) begin
            carry_next = pwdata[cpsw_pkg::BIT_ACC_POS];
        end
    end

    always_ff @(posedge pclk) begin
        carry_reg <= carry_next;
    end

    // ---------------------------------------------------------------
    // remaining fields
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_reg <= cpsw_pkg::SC_RESET;
            is_reg <= cpsw_pkg::IS_RESET;
            mem_en_reg <= cpsw_pkg::MEM_EN_RESET;
            reg_en_reg <= cpsw_pkg::REG_EN_RESET;
            bank_sel_reg <= cpsw_pkg::BANK_ZERO;
        end else begin
            if (skip_we) begin
                sc_reg <= skip_flags_in;
            end
            if (wr_status) begin
                is_reg <= pwdata[cpsw_pkg::IS_LSB +: cpsw_pkg::IS_W];
                mem_en_reg <= pwdata[cpsw_pkg::MEM_EN_BIT];
                reg_en_reg <= pwdata[cpsw_pkg::REG_EN_BIT];
            end
            if (bank_sel_we) begin
                bank_sel_reg <= bank_sel_in;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs to the core
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service_level_field <= cpsw_pkg::IS_RESET;
            service_high_only <= 1'b0;
            working_bank <= cpsw_pkg::BANK_ZERO;
        end else begin
            service_level_field <= is_reg;
            service_high_only <= (is_reg == cpsw_pkg::SVC_HIGH_ONLY);
            working_bank <= bank_next;
        end
    end

    cpsw_dmem_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .mem_en(mem_en_reg),
        .req(dmem_req),
        .rsp(dmem_rsp)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_carry_alu: assert property (
        !first_reg && alu_carry_we |=> carry_reg == $past(alu_carry))
        else $error("carry did not follow arithmetic result");
    chk_skip_readonly: assert property (
        wr_status && !skip_we |=> sc_reg == $past(sc_reg))
        else $error("skip flags changed by software write");
    chk_high_only_level: assert property (
        is_reg == cpsw_pkg::SVC_HIGH_ONLY ##1 is_reg == cpsw_pkg::SVC_HIGH_ONLY |-> service_high_only)
        else $error("high-priority only level not shown");
    chk_narrow_window: assert property (
        dmem_req.valid && !mem_en_reg |=> dmem_rsp.grant == cpsw_pkg::in_window(1'b0, $past(dmem_req.addr)))
        else $error("narrow window grant wrong");
    chk_full_window: assert property (
        dmem_req.valid && mem_en_reg |=> dmem_rsp.fault == !cpsw_pkg::in_window(1'b1, $past(dmem_req.addr)))
        else $error("full window grant wrong");
    chk_carry_keep: assert property (
        first_reg && pd_last_reg |=> carry_reg == $past(carry_reg))
        else $error("carry lost over power-down reset");
    chk_carry_wide_write: assert property (
        wr_status && !alu_carry_we && !first_reg |=> $stable(carry_reg))
        else $error("carry changed by word write");
    chk_work_bank: assert property (
        !reg_en_reg ##1 !reg_en_reg |-> working_bank == cpsw_pkg::BANK_ZERO)
        else $error("working bank not zero with flag clear");
    chk_apb_ready: assert property (
        setup |=> pready ##1 !pready || setup)
        else $error("apb answer timing wrong");

    cov_bit_write: cover property (wr_carry ##1 carry_reg == $past(pwdata[0]));
    cov_high_only: cover property (service_high_only);
    cov_fault: cover property (dmem_rsp.fault);
    chk_unmapped_err: assert property (
        setup && unmapped |=> pready && pslverr && prdata == '0)
        else $error("unmapped access not refused");
    chk_read_idle: assert property (
        !pready |-> prdata == '0 && !pslverr)
        else $error("read data or error outside access phase");

    cov_unmapped: cover property (pready && pslverr);
    cov_retention: cover property (first_reg && pd_last_reg && carry_reg);
endmodule // cpsw_status
`default_nettype wire

/* File: bench/tb_cpsw_status.sv */
// self-checking bench for the processor status word block
`timescale 1ns/10ps
`default_nettype none
module tb_cpsw_status;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic alu_carry_we, alu_carry, skip_we, bank_sel_we, power_down, service_high_only;
    logic [2:0] skip_flags_in;
    logic [3:0] bank_sel_in, working_bank;
    logic [1:0] service_level_field;
    cpsw_pkg::cpsw_dmem_req_s dmem_req;
    cpsw_pkg::cpsw_dmem_rsp_s dmem_rsp;
    int n_mismatch = 0;
    int checks = 0;
    logic [11:0] corner [0:7] = '{12'h07F, 12'h080, 12'hF7F, 12'hF80, 12'hFFF, 12'h4FF, 12'h500, 12'hEFF};
    cpsw_status dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alu_carry_we(alu_carry_we), .alu_carry(alu_carry), .skip_we(skip_we), .skip_flags_in(skip_flags_in),
        .bank_sel_we(bank_sel_we), .bank_sel_in(bank_sel_in), .power_down(power_down), .dmem_req(dmem_req),
        .dmem_rsp(dmem_rsp), .service_level_field(service_level_field),
        .service_high_only(service_high_only), .working_bank(working_bank));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic grant_exp(input logic mem_en, input logic [11:0] a);
        if (mem_en) return (a[11:8] <= 4'h4) || (a[11:8] == 4'hF);
        return (a <= 12'h07F) || (a >= 12'hF80);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait: no slave latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int which, input logic [3:0] v);
        @(posedge pclk);
        alu_carry_we <= (which == 0);
        alu_carry <= v[0];
        skip_we <= (which == 1);
        skip_flags_in <= v[2:0];
        bank_sel_we <= (which == 2);
        bank_sel_in <= v;
        @(posedge pclk);
        {alu_carry_we, skip_we, bank_sel_we} <= 3'h0;
    endtask
    task automatic mem(input logic mem_en, input logic [11:0] a);
        @(posedge pclk);
        dmem_req <= {1'b1, a};
        @(posedge pclk);
        dmem_req.valid <= 1'b0;
        #1;
        chk({30'h0, dmem_rsp}, {30'h0, grant_exp(mem_en, a), !grant_exp(mem_en, a)});
    endtask
    // power_down one cycle ahead of reset decides carry retention
    task automatic rst(input logic pd);
        @(posedge pclk);
        power_down <= pd;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        power_down <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, alu_carry_we, alu_carry, skip_we, bank_sel_we, power_down, presetn} = 9'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        skip_flags_in = 3'h0;
        bank_sel_in = 4'h0;
        dmem_req = '0;
        seed = 32'hF262;
        // power-down sampler is unknown until first_reg has fallen once, so a normal reset follows
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rst(1'b0);
        apb(1'b0, cpsw_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            pulse(2, seed[7:4]);
            apb(1'b1, cpsw_pkg::OFF_STATUS, seed | 32'hF0);
            apb(1'b1, cpsw_pkg::OFF_BANK, 32'hF);
            apb(1'b0, cpsw_pkg::OFF_STATUS, 32'h0);
            chk(rd, {28'h0, seed[3:0]});
            chk({service_high_only, service_level_field}, {seed[3:2] == 2'h1, seed[3:2]});
            chk(working_bank, seed[0] ? seed[7:4] : 4'h0);
            apb(1'b0, cpsw_pkg::OFF_BANK, 32'h0);
            chk(rd, {28'h0, (seed[0] ? seed[7:4] : 4'h0)});
            mem(seed[1], seed[19:8]);
        end
        $display("test fields done");
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, cpsw_pkg::OFF_STATUS, {30'h0, e[0], 1'b0});
            for (int k = 0; k < 8; k++) begin
                mem(e[0], corner[k]);
            end
            mem(e[0], 12'h000);
            mem(e[0], 12'h07F);
            mem(e[0], 12'h080);
            mem(e[0], 12'hF80);
            mem(e[0], 12'h4FF);
            mem(e[0], 12'h500);
        end
        $display("test windows done");
        pulse(1, 4'h5);
        apb(1'b1, cpsw_pkg::OFF_STATUS, 32'h0);
        apb(1'b0, cpsw_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h50);
        pulse(0, 4'h1);
        apb(1'b1, cpsw_pkg::OFF_STATUS, 32'h0);
        apb(1'b0, cpsw_pkg::OFF_STATUS, 32'h0);
        chk(rd[7], 1'b1);
        pulse(0, 4'h0);
        apb(1'b0, cpsw_pkg::OFF_CARRY, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, cpsw_pkg::OFF_CARRY, 32'h1);
        apb(1'b0, cpsw_pkg::OFF_CARRY, 32'h0);
        chk(rd, 32'h1);
        $display("test carry done");
        rst(1'b1);
        apb(1'b0, cpsw_pkg::OFF_CARRY, 32'h0);
        chk(rd, 32'h1);
        rst(1'b0);
        apb(1'b0, cpsw_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test retention done");
        stop_test();
    end
endmodule // tb_cpsw_status
`default_nettype wire
